// file: design/pacd_config_regs.sv
// Overview of operation
// - Three-bit field routes each channel to bridge
// - Routing register resets to its default
// - One enable bit per channel, default off
// - Shared bridge: flag error, bridge high impedance
// - Bit 15 reads zero; reserved bits writable
// - Two-bit pre-charge time, 125 to 1000 ns
// - Two-bit pre-discharge time, same encoding
// - Bit 14 enables deep adaptation
// - Bit 12 enables generator mode detection
// - Bits 15/14 pick sense amplifier side
// - Two-bit overcurrent filter, 6 to 100 us
// - Bits 9/8 switch sense amplifiers off
// - Bits 7..0 enable bridge diagnostic pull-downs
// - Static mode: 01 low, 10 high, else off
`timescale 1ns/1ps
`default_nettype none
`include "pacd_params.svh"

module pacd_config_regs #(
	parameter int NUM_BRIDGES = 8
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	// Register port from the serial interface
	input  wire logic                       reg_wr_en,
	input  wire logic                       reg_rd_en,
	input  wire logic [`PACD_ADDR_W-1:0]    reg_addr,
	input  wire logic [15:0]                reg_wr_data,
	output logic      [15:0]                reg_rd_data,
	output logic                            reg_rd_valid,
	// Static half-bridge modes, two bits per bridge
	input  wire logic [2*NUM_BRIDGES-1:0]   bridge_static_state,
	// Channel routing
	output logic      [2:0]                 chan1_bridge_select,
	output logic      [2:0]                 chan2_bridge_select,
	output logic      [2:0]                 chan3_bridge_select,
	output logic                            chan1_activate,
	output logic                            chan2_activate,
	output logic                            chan3_activate,
	// Pre-charge timing, in clock cycles
	output logic      [12:0]                chan1_precharge_time,
	output logic      [12:0]                chan2_precharge_time,
	output logic      [12:0]                chan3_precharge_time,
	output logic      [12:0]                chan1_predischarge_time,
	output logic      [12:0]                chan2_predischarge_time,
	output logic      [12:0]                chan3_predischarge_time,
	output logic                            deep_adapt_on,
	output logic                            generator_detect_on,
	// Sense amplifiers and diagnostics
	output logic                            sense_amp1_side,
	output logic                            sense_amp2_side,
	output logic      [12:0]                overcurrent1_filter,
	output logic      [12:0]                overcurrent2_filter,
	output logic                            sense_amp1_disable,
	output logic                            sense_amp2_disable,
	output logic      [NUM_BRIDGES-1:0]     bridge_diag_pulldown,
	// Bridge drive decisions
	output logic      [NUM_BRIDGES-1:0]     bridge_hiz,
	output logic      [NUM_BRIDGES-1:0]     bridge_ls_on,
	output logic      [NUM_BRIDGES-1:0]     bridge_hs_on,
	output logic      [NUM_BRIDGES-1:0]     bridge_pwm_on,
	output logic      [NUM_BRIDGES-1:0]     bridge_conflict,
	output logic                            map_error_pulse
);

	// Stored registers
	pacd_pkg::pacd_word_t routing;           // Channel routing
	pacd_pkg::pacd_word_t next_routing;
	pacd_pkg::pacd_word_t precharge;         // Pre-charge timing
	pacd_pkg::pacd_word_t next_precharge;
	pacd_pkg::pacd_word_t diag;              // Diagnostic control
	pacd_pkg::pacd_word_t next_diag;
	logic [15:0]          next_rd_data;
	logic                 next_rd_valid;

	// Register write and read decode
	always_comb begin
		next_routing   = routing;
		next_precharge = precharge;
		next_diag      = diag;
		next_rd_data   = 16'h0000;
		next_rd_valid  = reg_rd_en;
		if (reg_wr_en) begin
			unique case (reg_addr)
				`PACD_OFS_ROUTING: begin
					// Top bit is read-only zero, reserved bits kept as written
					next_routing = reg_wr_data;
					next_routing[`PACD_RT_ZERO_BIT] = 1'b0;
				end
				// Host keeps the reserved bits at zero; stored as given
				`PACD_OFS_PRECHARGE: next_precharge = reg_wr_data;
				`PACD_OFS_DIAG:      next_diag = reg_wr_data;
				default: ;
			endcase
		end
		if (reg_rd_en) begin
			unique case (reg_addr)
				`PACD_OFS_ROUTING:   next_rd_data = routing;
				`PACD_OFS_PRECHARGE: next_rd_data = precharge;
				`PACD_OFS_DIAG:      next_rd_data = diag;
				// Unmapped addresses read as zero
				default:             next_rd_data = 16'h0000;
			endcase
		end
	end

	// Register storage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			routing      <= `PACD_RST_ROUTING;
			precharge    <= `PACD_RST_PRECHARGE;
			diag         <= `PACD_RST_DIAG;
			reg_rd_data  <= 16'h0000;
			reg_rd_valid <= 1'b0;
		end else begin
			routing      <= next_routing;
			precharge    <= next_precharge;
			diag         <= next_diag;
			reg_rd_data  <= next_rd_data;
			reg_rd_valid <= next_rd_valid;
		end
	end

	// Field views of the routing register
	logic [2:0] sel [3];                     // Bridge code per channel
	logic [2:0] act;                         // Enable per channel
	assign sel[0] = routing[`PACD_RT_CH1_SEL_LSB +: 3];
	assign sel[1] = routing[`PACD_RT_CH2_SEL_LSB +: 3];
	assign sel[2] = routing[`PACD_RT_CH3_SEL_LSB +: 3];
	assign act    = {routing[`PACD_RT_CH3_EN], routing[`PACD_RT_CH2_EN],
			routing[`PACD_RT_CH1_EN]};

	// Drive decision state
	logic [NUM_BRIDGES-1:0] next_hiz;
	logic [NUM_BRIDGES-1:0] next_ls;
	logic [NUM_BRIDGES-1:0] next_hs;
	logic [NUM_BRIDGES-1:0] next_pwm;
	logic [NUM_BRIDGES-1:0] next_conflict;
	logic                   next_err;

	// Per-bridge ownership and conflict, recomputed every cycle
	always_comb begin
		logic [1:0] owners;
		logic [1:0] mode;
		owners        = 2'h0;
		mode          = 2'h0;
		next_hiz      = '0;
		next_ls       = '0;
		next_hs       = '0;
		next_pwm      = '0;
		next_conflict = '0;
		for (int b = 0; b < NUM_BRIDGES; b++) begin
			owners = 2'h0;
			for (int c = 0; c < 3; c++) begin
				// Code 000 is bridge 1 up to 111 for bridge 8
				if (act[c] && (sel[c] == 3'(b))) begin
					owners = owners + 2'h1;
				end
			end
			mode = bridge_static_state[2*b +: 2];
			if (owners > 2'h1) begin
				// Shared bridge is parked, releases once unshared
				next_conflict[b] = 1'b1;
				next_hiz[b]      = 1'b1;
			end else if (owners == 2'h1) begin
				next_pwm[b] = 1'b1;
			end else if (mode == `PACD_MODE_LS_ON) begin
				next_ls[b] = 1'b1;
			end else if (mode == `PACD_MODE_HS_ON) begin
				next_hs[b] = 1'b1;
			end else begin
				// Both 00 and the reserved 11 leave the bridge off
				next_hiz[b] = 1'b1;
			end
		end
		// Error flagged once per new conflict, not every cycle
		next_err = |(next_conflict & ~bridge_conflict);
	end

	// Drive decision registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bridge_hiz      <= '1;
			bridge_ls_on    <= '0;
			bridge_hs_on    <= '0;
			bridge_pwm_on   <= '0;
			bridge_conflict <= '0;
			map_error_pulse <= 1'b0;
		end else begin
			bridge_hiz      <= next_hiz;
			bridge_ls_on    <= next_ls;
			bridge_hs_on    <= next_hs;
			bridge_pwm_on   <= next_pwm;
			bridge_conflict <= next_conflict;
			map_error_pulse <= next_err;
		end
	end

	// Configuration outputs straight from register fields
	always_comb begin
		chan1_bridge_select     = sel[0];
		chan2_bridge_select     = sel[1];
		chan3_bridge_select     = sel[2];
		chan1_activate          = act[0];
		chan2_activate          = act[1];
		chan3_activate          = act[2];
		chan1_precharge_time    = pacd_pkg::pacd_pchg_cycles(
				precharge[`PACD_PT_CH1_PCHG_LSB +: 2]);
		chan2_precharge_time    = pacd_pkg::pacd_pchg_cycles(
				precharge[`PACD_PT_CH2_PCHG_LSB +: 2]);
		chan3_precharge_time    = pacd_pkg::pacd_pchg_cycles(
				precharge[`PACD_PT_CH3_PCHG_LSB +: 2]);
		chan1_predischarge_time = pacd_pkg::pacd_pchg_cycles(
				precharge[`PACD_PT_CH1_PDCHG_LSB +: 2]);
		chan2_predischarge_time = pacd_pkg::pacd_pchg_cycles(
				precharge[`PACD_PT_CH2_PDCHG_LSB +: 2]);
		chan3_predischarge_time = pacd_pkg::pacd_pchg_cycles(
				precharge[`PACD_PT_CH3_PDCHG_LSB +: 2]);
		deep_adapt_on           = precharge[`PACD_PT_DEEP_ADAPT];
		generator_detect_on     = precharge[`PACD_PT_GEN_DETECT];
		sense_amp2_side         = diag[`PACD_DG_AMP2_SIDE];
		sense_amp1_side         = diag[`PACD_DG_AMP1_SIDE];
		overcurrent2_filter     = pacd_pkg::pacd_ocf_cycles(
				diag[`PACD_DG_OC2_FILT_LSB +: 2]);
		overcurrent1_filter     = pacd_pkg::pacd_ocf_cycles(
				diag[`PACD_DG_OC1_FILT_LSB +: 2]);
		sense_amp2_disable      = diag[`PACD_DG_AMP2_OFF];
		sense_amp1_disable      = diag[`PACD_DG_AMP1_OFF];
		bridge_diag_pulldown    = diag[`PACD_DG_PULLDOWN_LSB +: NUM_BRIDGES];
	end

endmodule : pacd_config_regs

`default_nettype wire

// file: design/pacd_params.svh
`ifndef PACD_PARAMS_SVH
`define PACD_PARAMS_SVH

// Clock rate in MHz (25 ns period)
`define PACD_CLK_MHZ           40

// Register offsets on the serial register port
`define PACD_ADDR_W            5
`define PACD_OFS_ROUTING       5'h07
`define PACD_OFS_PRECHARGE     5'h08
`define PACD_OFS_DIAG          5'h09

// Reset values
`define PACD_RST_ROUTING       16'h6c60
`define PACD_RST_PRECHARGE     16'h0000
`define PACD_RST_DIAG          16'hc000

// Routing register fields
`define PACD_RT_ZERO_BIT       15
`define PACD_RT_CH3_SEL_LSB    9
`define PACD_RT_CH3_EN         8
`define PACD_RT_CH2_SEL_LSB    5
`define PACD_RT_CH2_EN         4
`define PACD_RT_CH1_SEL_LSB    1
`define PACD_RT_CH1_EN         0

// Pre-charge timing register fields
`define PACD_PT_DEEP_ADAPT     14
`define PACD_PT_GEN_DETECT     12
`define PACD_PT_CH3_PDCHG_LSB  10
`define PACD_PT_CH3_PCHG_LSB   8
`define PACD_PT_CH2_PDCHG_LSB  6
`define PACD_PT_CH2_PCHG_LSB   4
`define PACD_PT_CH1_PDCHG_LSB  2
`define PACD_PT_CH1_PCHG_LSB   0

// Diagnostic control register fields
`define PACD_DG_AMP2_SIDE      15
`define PACD_DG_AMP1_SIDE      14
`define PACD_DG_OC2_FILT_LSB   12
`define PACD_DG_OC1_FILT_LSB   10
`define PACD_DG_AMP2_OFF       9
`define PACD_DG_AMP1_OFF       8
`define PACD_DG_PULLDOWN_LSB   0

// Pre-charge / pre-discharge step times in ns
`define PACD_PCHG_NS_0         125
`define PACD_PCHG_NS_1         250
`define PACD_PCHG_NS_2         500
`define PACD_PCHG_NS_3         1000

// Overcurrent filter times in us
`define PACD_OCF_US_0          6
`define PACD_OCF_US_1          10
`define PACD_OCF_US_2          50
`define PACD_OCF_US_3          100

// Static bridge mode codes
`define PACD_MODE_LS_ON        2'h1
`define PACD_MODE_HS_ON        2'h2

`endif

// file: design/pacd_pkg.sv
`include "pacd_params.svh"

package pacd_pkg;

	// Register word and field types
	typedef logic [15:0] pacd_word_t;
	typedef logic [2:0]  pacd_bridge_sel_t;
	typedef logic [1:0]  pacd_code_t;
	typedef logic [12:0] pacd_cycles_t;

	// Pre-charge code to cycles, a least time so rounded up
	function automatic pacd_cycles_t pacd_pchg_cycles(input pacd_code_t code);
		int ns;
		ns = `PACD_PCHG_NS_0;
		unique case (code)
			2'h0: ns = `PACD_PCHG_NS_0;
			2'h1: ns = `PACD_PCHG_NS_1;
			2'h2: ns = `PACD_PCHG_NS_2;
			2'h3: ns = `PACD_PCHG_NS_3;
		endcase
		return pacd_cycles_t'((ns * `PACD_CLK_MHZ + 999) / 1000);
	endfunction : pacd_pchg_cycles

	// Overcurrent filter code to cycles
	function automatic pacd_cycles_t pacd_ocf_cycles(input pacd_code_t code);
		int us;
		us = `PACD_OCF_US_0;
		unique case (code)
			2'h0: us = `PACD_OCF_US_0;
			2'h1: us = `PACD_OCF_US_1;
			2'h2: us = `PACD_OCF_US_2;
			2'h3: us = `PACD_OCF_US_3;
		endcase
		return pacd_cycles_t'(us * `PACD_CLK_MHZ);
	endfunction : pacd_ocf_cycles

endpackage : pacd_pkg

// file: test/pacd_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "pacd_params.svh"

// Port-level watch over the configuration slice
module pacd_chk #(
	parameter int NUM_BRIDGES = 8
) (
	// Clock, reset and register port
	input wire logic				clk,
	input wire logic				sys_rst,
	input wire logic				reg_wr_en,
	input wire logic				reg_rd_en,
	input wire logic [4:0]			reg_addr,
	input wire logic [15:0]			reg_wr_data,
	input wire logic [15:0]			reg_rd_data,
	input wire logic				reg_rd_valid,
	// Configuration outputs
	input wire logic [2*NUM_BRIDGES-1:0]	bridge_static_state,
	input wire logic [2:0]			chan1_bridge_select,
	input wire logic [2:0]			chan2_bridge_select,
	input wire logic [2:0]			chan3_bridge_select,
	input wire logic				chan1_activate,
	input wire logic				chan2_activate,
	input wire logic				chan3_activate,
	input wire logic				deep_adapt_on,
	input wire logic				generator_detect_on,
	input wire logic				sense_amp1_side,
	input wire logic				sense_amp2_side,
	input wire logic [NUM_BRIDGES-1:0]	bridge_diag_pulldown,
	// Drive decisions
	input wire logic [NUM_BRIDGES-1:0]	bridge_hiz,
	input wire logic [NUM_BRIDGES-1:0]	bridge_ls_on,
	input wire logic [NUM_BRIDGES-1:0]	bridge_hs_on,
	input wire logic [NUM_BRIDGES-1:0]	bridge_conflict,
	input wire logic				map_error_pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Bridges claimed by two or more live channels now
	logic [NUM_BRIDGES-1:0]	clash;
	always_comb begin
		for (int b = 0; b < NUM_BRIDGES; b++) begin
			clash[b] = 2'(chan1_activate && chan1_bridge_select == 3'(b))
				+ 2'(chan2_activate && chan2_bridge_select == 3'(b))
				+ 2'(chan3_activate && chan3_bridge_select == 3'(b)) > 2'd1;
		end
	end

	// A write taken at one offset
	sequence s_wr(logic [4:0] a);
		reg_wr_en && reg_addr == a;
	endsequence

	a_route_fields: assert property (s_wr(`PACD_OFS_ROUTING) |=>
		{chan3_bridge_select, chan3_activate, chan2_bridge_select, chan2_activate,
		chan1_bridge_select, chan1_activate} == $past(reg_wr_data[11:0]))
		else $error("routing fields differ from written word");
	a_zero_bit: assert property (reg_rd_en && reg_addr == `PACD_OFS_ROUTING |=>
		reg_rd_valid && !reg_rd_data[15]) else $error("routing top bit not zero");
	a_clash_hiz: assert property ((bridge_conflict & ~bridge_hiz) == '0)
		else $error("shared bridge is driven");
	a_error_cause: assert property (map_error_pulse |->
		(bridge_conflict & ~$past(bridge_conflict)) != '0) else $error("error without new clash");
	a_error_new: assert property ((bridge_conflict & ~$past(bridge_conflict)) != '0 |->
		map_error_pulse) else $error("new clash without error");
	a_clash_live: assert property (bridge_conflict == $past(clash))
		else $error("conflict flags do not follow routing");
	a_timing_enables: assert property (s_wr(`PACD_OFS_PRECHARGE) |=>
		{deep_adapt_on, generator_detect_on} == {$past(reg_wr_data[14]), $past(reg_wr_data[12])})
		else $error("timing enables differ from write");
	a_diag_fields: assert property (s_wr(`PACD_OFS_DIAG) |=>
		{sense_amp2_side, sense_amp1_side, bridge_diag_pulldown}
		== {$past(reg_wr_data[15:14]), $past(reg_wr_data[7:0])}) else $error("diag fields differ");
	// Static drive only ever follows the mode seen one cycle earlier
	for (genvar i = 0; i < NUM_BRIDGES; i++) begin : g_st
		a_static_drive: assert property ((bridge_ls_on[i] || bridge_hs_on[i]) |->
			$past(bridge_static_state[2*i+:2]) == {bridge_hs_on[i], bridge_ls_on[i]}
			&& !bridge_conflict[i]) else $error("static drive differs from mode");
	end
endmodule : pacd_chk

bind pacd_config_regs pacd_chk #(.NUM_BRIDGES(NUM_BRIDGES)) u_chk (.*);
`default_nettype wire

// file: test/pacd_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pacd_params.svh"

// Host on the register port; changes requests only after an edge
module pacd_host (
	// Clock and answer
	input wire logic		clk,
	input wire logic [15:0]	reg_rd_data,
	input wire logic		reg_rd_valid,
	// Requests
	output logic			reg_wr_en,
	output logic			reg_rd_en,
	output logic [4:0]		reg_addr,
	output logic [15:0]		reg_wr_data
);
	// Idle port at time zero
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 5'h00;
		reg_wr_data = 16'h0000;
	end

	// One write; reserved fields kept as the device wants them
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (a == `PACD_OFS_ROUTING) v[14:12] = 3'h6;
		if (a == `PACD_OFS_PRECHARGE) v = v & 16'h5fff;
		@(posedge clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		// Released data toggles so a stale word cannot look valid
		reg_wr_data <= ~v;
	endtask : wr

	// One read; answer taken one edge after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		@(posedge clk);
		ok = reg_rd_valid;
		d = reg_rd_data;
	endtask : rd
endmodule : pacd_host
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pacd_params.svh"

module tb_top;
	// Clock, reset, port and outputs
	logic			clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, map_error_pulse;
	logic [4:0]		reg_addr;
	logic [15:0]	reg_wr_data, reg_rd_data, bridge_static_state;
	logic [2:0]		chan1_bridge_select, chan2_bridge_select, chan3_bridge_select;
	logic			chan1_activate, chan2_activate, chan3_activate;
	logic [12:0]	chan1_precharge_time, chan2_precharge_time, chan3_precharge_time;
	logic [12:0]	chan1_predischarge_time, chan2_predischarge_time, chan3_predischarge_time;
	logic [12:0]	overcurrent1_filter, overcurrent2_filter;
	logic			deep_adapt_on, generator_detect_on, sense_amp1_side, sense_amp2_side;
	logic			sense_amp1_disable, sense_amp2_disable;
	logic [7:0]		bridge_diag_pulldown, bridge_hiz, bridge_ls_on, bridge_hs_on;
	logic [7:0]		bridge_pwm_on, bridge_conflict, prev;
	int				mismatches, cmp_count, pulses, p0;
	logic [15:0]	r, t, g, s;
	logic [39:0]	e;

	pacd_config_regs #(.NUM_BRIDGES(8)) dut (.*);
	pacd_host h (.*);

	// 25 ns clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Error pulses seen so far
	always @(posedge clk) if (map_error_pulse === 1'b1) pulses++;

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic final_report;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	// Step time in cycles, rounded up to a whole cycle
	function automatic logic [15:0] pcyc(input logic [1:0] c);
		return 16'((125 * (1 << c) * `PACD_CLK_MHZ + 999) / 1000);
	endfunction : pcyc

	function automatic logic [15:0] ocyc(input logic [1:0] c);
		return 16'((c == 0 ? 6 : c == 1 ? 10 : c == 2 ? 50 : 100) * `PACD_CLK_MHZ);
	endfunction : ocyc

	// Expected {conflict, pwm, hs, ls, hiz} per bridge
	function automatic logic [39:0] drive(input logic [15:0] w, input logic [15:0] m);
		logic [7:0] cf, pw, hs, ls, hz;
		int n;
		for (int b = 0; b < 8; b++) begin
			n = int'(w[0] && w[3:1] == 3'(b)) + int'(w[4] && w[7:5] == 3'(b))
				+ int'(w[8] && w[11:9] == 3'(b));
			cf[b] = n > 1;
			pw[b] = n == 1;
			ls[b] = n == 0 && m[2*b+:2] == 2'h1;
			hs[b] = n == 0 && m[2*b+:2] == 2'h2;
			hz[b] = !(pw[b] || ls[b] || hs[b]);
		end
		return {cf, pw, hs, ls, hz};
	endfunction : drive

	// Read back all offsets, one unmapped, then every output but map_error_pulse
	task automatic check_all;
		logic [15:0] d, w [4];
		logic ok;
		w = '{r & 16'h7fff, t, g, 16'h0000};
		e = drive(r, s);
		for (int i = 0; i < 4; i++) begin
			h.rd(5'(7 + i), d, ok);
			chk("rd_valid", {15'h0, ok}, 16'h0001);
			chk("rd_data", d, w[i]);
		end
		chk("route", {4'h0, chan3_bridge_select, chan3_activate, chan2_bridge_select,
			chan2_activate, chan1_bridge_select, chan1_activate}, {4'h0, r[11:0]});
		chk("pchg1", 16'(chan1_precharge_time), pcyc(t[1:0]));
		chk("pchg2", 16'(chan2_precharge_time), pcyc(t[5:4]));
		chk("pchg3", 16'(chan3_precharge_time), pcyc(t[9:8]));
		chk("pdch1", 16'(chan1_predischarge_time), pcyc(t[3:2]));
		chk("pdch2", 16'(chan2_predischarge_time), pcyc(t[7:6]));
		chk("pdch3", 16'(chan3_predischarge_time), pcyc(t[11:10]));
		chk("flags", {14'h0, deep_adapt_on, generator_detect_on}, {14'h0, t[14], t[12]});
		chk("diag", {sense_amp2_side, sense_amp1_side, 4'h0, sense_amp2_disable,
			sense_amp1_disable, bridge_diag_pulldown}, g & 16'hc3ff);
		chk("ocf1", 16'(overcurrent1_filter), ocyc(g[11:10]));
		chk("ocf2", 16'(overcurrent2_filter), ocyc(g[13:12]));
		chk("clash", {bridge_conflict, bridge_pwm_on}, e[39:24]);
		chk("static", {bridge_hs_on, bridge_ls_on}, e[23:8]);
		chk("hiz", {8'h0, bridge_hiz}, {8'h0, e[7:0]});
	endtask : check_all

	// Reset defaults, three routing corners, then random words
	initial begin
		sys_rst = 1'b1;
		bridge_static_state = 16'h0000;
		void'($urandom(32'h18f05aac));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		r = 16'h6c60;
		t = 16'h0000;
		g = 16'hc000;
		s = 16'h0000;
		check_all();
		prev = 8'h00;
		for (int k = 0; k < 40; k++) begin
			// Shared bridge, ownership moved, then cleared
			r = k == 0 ? 16'h6111 : k == 1 ? 16'h6113 : k == 2 ? 16'h6f35 : 16'($urandom);
			r[14:12] = 3'h6;
			t = 16'($urandom) & 16'h5fff;
			g = 16'($urandom);
			s = 16'($urandom);
			p0 = pulses;
			h.wr(`PACD_OFS_ROUTING, r);
			h.wr(`PACD_OFS_PRECHARGE, t);
			h.wr(`PACD_OFS_DIAG, g);
			// Unmapped offset must leave every register alone
			h.wr(5'h0a, ~g);
			@(posedge clk);
			bridge_static_state <= s;
			check_all();
			chk("pulse", 16'(pulses - p0), {15'h0, |(e[39:32] & ~prev)});
			prev = e[39:32];
		end
		// Reset again mid-run; defaults must come back
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		r = 16'h6c60;
		t = 16'h0000;
		g = 16'hc000;
		check_all();
		final_report();
	end

	// Hang guard, well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end
endmodule : tb_top
`default_nettype wire
